// *** hdl/mcod_top.v ***
// Contract
// [RQ1] 3-bit alu field: 0-4 general regs, 5 immediate, 6 product high, 7 product low
// [RQ2] general-or-immediate field: 0-4 general regs, 5 immediate, no product words
// [RQ3] 5-bit core field: alu regs, aux, jump targets, counters, counter limits
// [RQ4] 5-bit core field: flag, spi data, dac selections, fourth dac, spi address
// [RQ5] 5-bit core field: math word, control, status bits, irq status, exchange
// [RQ6] jump select bit: 0 first jump target, 1 second jump target
// [RQ7] add writes first plus second source into destination, carry into carry flag
// [RQ8] add sources and destination all come from the 3-bit alu subset
// [RQ9] add updates carry, zero, negative, both unsigned and both signed flags
// [RQ10] add opcode 001010, destination, zero bit, second source, first source
//
// The APB register port and the address map are this design's own decisions.
`include "mcod_defines.vh"

module mcod_top #(
  parameter W     = `MCOD_DATA_W,
  parameter CNT_W = `MCOD_CNT_W
) (
  // clock and reset
  input  wire                        pclk,
  input  wire                        presetn,
  // apb slave
  input  wire                        psel,
  input  wire                        penable,
  input  wire                        pwrite,
  input  wire [`MCOD_ADDR_W-1:0]     paddr,
  input  wire [31:0]                 pwdata,
  output reg  [31:0]                 prdata,
  output reg                         pready,
  output reg                         pslverr,
  // code ram instruction stream
  input  wire                        instr_valid,
  input  wire [15:0]                 instr_word,
  // decode results of the last accepted word
  output reg  [`MCOD_CORE_SEL_W-1:0] alu_sel_id,
  output reg  [`MCOD_CORE_SEL_W-1:0] gpi_sel_id,
  output reg                         gpi_sel_ok,
  output reg  [2:0]                  core_sel_group,
  output reg  [1:0]                  core_sel_unit,
  output reg  [`MCOD_CORE_SEL_W-1:0] core_sel_id,
  output reg  [`MCOD_CORE_SEL_W-1:0] jump_sel_id,
  output reg                         decode_valid,
  // add execution
  output reg                         add_done,
  output reg  [`MCOD_FLAG_W-1:0]     cond_flags
);

  reg  [W-1:0]               alu_regs [0:7];
  reg                        exec_en;
  reg  [15:0]                last_instr;
  reg  [CNT_W-1:0]           add_count;
  reg  [CNT_W-1:0]           skip_count;

  wire [`MCOD_CORE_SEL_W-1:0] dec_alu_id;
  wire [`MCOD_CORE_SEL_W-1:0] dec_gpi_id;
  wire                        dec_gpi_ok;
  wire [2:0]                  dec_group;
  wire [1:0]                  dec_unit;
  wire [`MCOD_CORE_SEL_W-1:0] dec_jump_id;

  wire [`MCOD_ALU_SEL_W-1:0]  dst_sel;
  wire [`MCOD_ALU_SEL_W-1:0]  src1_sel;
  wire [`MCOD_ALU_SEL_W-1:0]  src2_sel;
  wire                        is_add;
  wire                        do_add;
  wire [W-1:0]                add_sum;
  wire [`MCOD_FLAG_W-1:0]     add_flags;

  wire                        apb_setup;
  wire                        apb_done;
  wire                        apb_wr;
  wire                        in_alu;
  wire [2:0]                  alu_wr_idx;

  // instruction fields
  assign dst_sel  = instr_word[`MCOD_DST_HI:`MCOD_DST_LO];     // [RQ10]
  assign src2_sel = instr_word[`MCOD_SRC2_HI:`MCOD_SRC2_LO];   // [RQ10]
  assign src1_sel = instr_word[`MCOD_SRC1_HI:`MCOD_SRC1_LO];   // [RQ10]
  // a set zero bit means another instruction, so it is not taken as add
  assign is_add = (instr_word[`MCOD_OPC_HI:`MCOD_OPC_LO] == `MCOD_OPC_ADD) &&
                  ~instr_word[`MCOD_ZERO_BIT];                  // [RQ10]
  assign do_add = instr_valid & exec_en & is_add;

  mcod_sel_decode u_dec (
    .alu_field  (src1_sel),
    .core_field (instr_word[`MCOD_CSEL_HI:0]),
    .jump_field (instr_word[`MCOD_JSEL_BIT]),
    .alu_id     (dec_alu_id),
    .gpi_id     (dec_gpi_id),
    .gpi_ok     (dec_gpi_ok),
    .core_group (dec_group),
    .core_unit  (dec_unit),
    .jump_id    (dec_jump_id)
  );

  // both operands read only from the eight-entry alu subset
  mcod_adder #(
    .W (W)
  ) u_add (
    .first_source  (alu_regs[src1_sel]),   // [RQ8]
    .second_source (alu_regs[src2_sel]),   // [RQ8]
    .sum           (add_sum),
    .flags         (add_flags)
  );

  // apb decode
  assign apb_setup  = psel & ~penable;
  assign apb_done   = psel & penable & pready;
  assign apb_wr     = apb_done & pwrite & ~pslverr;
  assign in_alu     = (paddr <= `MCOD_OFS_ALU_TOP) && (paddr[1:0] == 2'b00);
  assign alu_wr_idx = paddr[4:2];

  // register file: an apb write to the same word wins over the add write-back
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_alu
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          alu_regs[gi] <= `MCOD_RST_DATA;
        end else if (apb_wr && in_alu && alu_wr_idx == gi) begin
          alu_regs[gi] <= pwdata[W-1:0];
        end else if (do_add && dst_sel == gi) begin
          alu_regs[gi] <= add_sum;                  // [RQ7] [RQ8]
        end
      end
    end
  endgenerate

  // condition flags: an add in the same cycle as a clear wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_flags <= {`MCOD_FLAG_W{1'b0}};
    end else if (do_add) begin
      cond_flags <= add_flags;                      // [RQ7] [RQ9]
    end else if (apb_wr && paddr == `MCOD_OFS_FLAGS) begin
      cond_flags <= cond_flags & ~pwdata[`MCOD_FLAG_W-1:0];
    end
  end

  // control and counters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_en    <= `MCOD_CTRL_RST;
      add_count  <= {CNT_W{1'b0}};
      skip_count <= {CNT_W{1'b0}};
    end else begin
      if (apb_wr && paddr == `MCOD_OFS_CTRL)
        exec_en <= pwdata[`MCOD_CTRL_EXEC];
      if (apb_wr && paddr == `MCOD_OFS_ADDCNT) begin
        add_count  <= {CNT_W{1'b0}};
        skip_count <= {CNT_W{1'b0}};
      end else begin
        if (do_add)
          add_count <= add_count + {{(CNT_W-1){1'b0}}, 1'b1};
        // add words that arrive while execution is disabled are counted, not run
        if (instr_valid && is_add && !exec_en)
          skip_count <= skip_count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // registered decode outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_sel_id     <= 5'h00;
      gpi_sel_id     <= 5'h00;
      gpi_sel_ok     <= 1'b0;
      core_sel_group <= 3'h0;
      core_sel_unit  <= 2'h0;
      core_sel_id    <= 5'h00;
      jump_sel_id    <= 5'h00;
      decode_valid   <= 1'b0;
      add_done       <= 1'b0;
      last_instr     <= 16'h0000;
    end else begin
      decode_valid <= instr_valid;
      add_done     <= do_add;
      if (instr_valid) begin
        alu_sel_id     <= dec_alu_id;               // [RQ1]
        gpi_sel_id     <= dec_gpi_id;               // [RQ2]
        gpi_sel_ok     <= dec_gpi_ok;               // [RQ2]
        core_sel_group <= dec_group;                // [RQ3] [RQ4] [RQ5]
        core_sel_unit  <= dec_unit;
        core_sel_id    <= instr_word[`MCOD_CSEL_HI:0];
        jump_sel_id    <= dec_jump_id;              // [RQ6]
        last_instr     <= instr_word;
      end
    end
  end

  // apb answer: registered, ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (apb_setup) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (in_alu) begin
        prdata <= {{(32-W){1'b0}}, alu_regs[paddr[4:2]]};
      end else begin
        case (paddr)
          `MCOD_OFS_FLAGS:   prdata <= {25'h0000000, cond_flags};
          `MCOD_OFS_CTRL:    prdata <= {31'h00000000, exec_en};
          `MCOD_OFS_STATUS:  prdata <= {27'h0000000, core_sel_unit, core_sel_group};
          `MCOD_OFS_DECODE:  prdata <= {11'h000, gpi_sel_ok, jump_sel_id,
                                        gpi_sel_id, alu_sel_id, core_sel_id};
          `MCOD_OFS_LASTINS: prdata <= {16'h0000, last_instr};
          `MCOD_OFS_ADDCNT:  prdata <= {skip_count, add_count};
          default:           pslverr <= 1'b1;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// *** hdl/mcod_defines.vh ***
`ifndef MCOD_DEFINES_VH
`define MCOD_DEFINES_VH

// data path and field widths
`define MCOD_DATA_W        16
`define MCOD_ALU_SEL_W     3
`define MCOD_CORE_SEL_W    5
`define MCOD_FLAG_W        7

// alu-register subset codes (3-bit)
`define MCOD_ALU_R4        3'h4
`define MCOD_ALU_IMM       3'h5
`define MCOD_ALU_PHI       3'h6
`define MCOD_ALU_PLO       3'h7

// core-register subset codes (5-bit)
`define MCOD_CORE_ALU_LAST 5'h07
`define MCOD_CORE_MATH     5'h08
`define MCOD_CORE_AUX      5'h09
`define MCOD_CORE_JMP1     5'h0a
`define MCOD_CORE_JMP2     5'h0b
`define MCOD_CORE_COUNTER_ONE     5'h0c
`define MCOD_CORE_CNT4     5'h0f
`define MCOD_CORE_LIM1     5'h10
`define MCOD_CORE_LIM4     5'h13
`define MCOD_CORE_FLAG     5'h14
`define MCOD_CORE_CTRL     5'h15
`define MCOD_CORE_STAT     5'h16
`define MCOD_CORE_SPID     5'h17
`define MCOD_CORE_DAC1     5'h18
`define MCOD_CORE_DAC4     5'h1b
`define MCOD_CORE_DAC4N    5'h1c
`define MCOD_CORE_SPIA     5'h1d
`define MCOD_CORE_IRQ      5'h1e
`define MCOD_CORE_XCH      5'h1f

// register groups reported by the core-register decoder
`define MCOD_GRP_ALU       3'h0
`define MCOD_GRP_MATH      3'h1
`define MCOD_GRP_AUX       3'h2
`define MCOD_GRP_JUMP      3'h3
`define MCOD_GRP_COUNTER   3'h4
`define MCOD_GRP_LIMIT     3'h5
`define MCOD_GRP_SYSTEM    3'h6
`define MCOD_GRP_PERIPH    3'h7

// two-register add instruction layout
`define MCOD_OPC_HI        15
`define MCOD_OPC_LO        10
`define MCOD_OPC_ADD       6'h0a
`define MCOD_DST_HI        9
`define MCOD_DST_LO        7
`define MCOD_ZERO_BIT      6
`define MCOD_SRC2_HI       5
`define MCOD_SRC2_LO       3
`define MCOD_SRC1_HI       2
`define MCOD_SRC1_LO       0
`define MCOD_CSEL_HI       4
`define MCOD_JSEL_BIT      0

// flag bit positions
`define MCOD_FLG_C         0
`define MCOD_FLG_RZ        1
`define MCOD_FLG_RS        2
`define MCOD_FLG_UU        3
`define MCOD_FLG_UO        4
`define MCOD_FLG_SU        5
`define MCOD_FLG_SO        6

// apb register byte offsets
`define MCOD_ADDR_W        8
`define MCOD_OFS_ALU_BASE  8'h00
`define MCOD_OFS_ALU_TOP   8'h1c
`define MCOD_OFS_FLAGS     8'h20
`define MCOD_OFS_CTRL      8'h24
`define MCOD_OFS_STATUS    8'h28
`define MCOD_OFS_DECODE    8'h2c
`define MCOD_OFS_LASTINS   8'h30
`define MCOD_OFS_ADDCNT    8'h34

// ctrl bits and reset values
`define MCOD_CTRL_EXEC     0
`define MCOD_CTRL_RST      1'h0
`define MCOD_CNT_W         16
`define MCOD_RST_DATA      16'h0000

`endif

// *** hdl/mcod_adder.v ***
`include "mcod_defines.vh"

module mcod_adder #(
  parameter W = `MCOD_DATA_W
) (
  // operands
  input  wire [W-1:0]            first_source,
  input  wire [W-1:0]            second_source,
  // result
  output wire [W-1:0]            sum,
  output wire [`MCOD_FLAG_W-1:0] flags
);

  wire [W:0] wide;
  wire       s1;
  wire       s2;
  wire       sr;

  assign wide = {1'b0, first_source} + {1'b0, second_source};
  assign sum  = wide[W-1:0];
  assign s1   = first_source[W-1];
  assign s2   = second_source[W-1];
  assign sr   = wide[W-1];

  // an add can never borrow, so the unsigned-under flag is always cleared by it
  assign flags[`MCOD_FLG_C]  = wide[W];               // [RQ7]
  assign flags[`MCOD_FLG_RZ] = (wide[W-1:0] == {W{1'b0}}); // [RQ9]
  assign flags[`MCOD_FLG_RS] = sr;                    // [RQ9]
  assign flags[`MCOD_FLG_UU] = 1'b0;                  // [RQ9]
  assign flags[`MCOD_FLG_UO] = wide[W];               // [RQ9]
  assign flags[`MCOD_FLG_SU] = s1 & s2 & ~sr;         // [RQ9]
  assign flags[`MCOD_FLG_SO] = ~s1 & ~s2 & sr;        // [RQ9]

endmodule

// *** hdl/mcod_sel_decode.v ***
`include "mcod_defines.vh"

module mcod_sel_decode (
  // operand fields
  input  wire [`MCOD_ALU_SEL_W-1:0]  alu_field,
  input  wire [`MCOD_CORE_SEL_W-1:0] core_field,
  input  wire                        jump_field,
  // alu and general-or-immediate subsets
  output reg  [`MCOD_CORE_SEL_W-1:0] alu_id,
  output reg  [`MCOD_CORE_SEL_W-1:0] gpi_id,
  output reg                         gpi_ok,
  // core-register subset
  output reg  [2:0]                  core_group,
  output reg  [1:0]                  core_unit,
  // jump subset
  output reg  [`MCOD_CORE_SEL_W-1:0] jump_id
);

  always @* begin
    // alu codes share the low eight core-register indices
    alu_id = {2'b00, alu_field};                       // [RQ1]
    gpi_ok = (alu_field <= `MCOD_ALU_IMM);             // [RQ2]
    gpi_id = gpi_ok ? {2'b00, alu_field} : 5'h00;      // [RQ2]
    jump_id = jump_field ? `MCOD_CORE_JMP2 : `MCOD_CORE_JMP1; // [RQ6]
    core_unit = core_field[1:0];
    if (core_field <= `MCOD_CORE_ALU_LAST) begin
      core_group = `MCOD_GRP_ALU;                      // [RQ3]
      core_unit  = 2'h0;
    end else if (core_field == `MCOD_CORE_MATH) begin
      core_group = `MCOD_GRP_MATH;                     // [RQ5]
      core_unit  = 2'h0;
    end else if (core_field == `MCOD_CORE_AUX) begin
      core_group = `MCOD_GRP_AUX;                      // [RQ3]
      core_unit  = 2'h0;
    end else if (core_field <= `MCOD_CORE_JMP2) begin
      core_group = `MCOD_GRP_JUMP;                     // [RQ3]
      core_unit  = {1'b0, core_field[0]};
    end else if (core_field <= `MCOD_CORE_CNT4) begin
      core_group = `MCOD_GRP_COUNTER;                  // [RQ3]
    end else if (core_field <= `MCOD_CORE_LIM4) begin
      core_group = `MCOD_GRP_LIMIT;                    // [RQ3]
    end else if (core_field == `MCOD_CORE_FLAG ||
                 core_field == `MCOD_CORE_CTRL ||
                 core_field == `MCOD_CORE_STAT ||
                 core_field == `MCOD_CORE_IRQ  ||
                 core_field == `MCOD_CORE_XCH) begin
      core_group = `MCOD_GRP_SYSTEM;                   // [RQ4] [RQ5]
    end else begin
      // spi data, four dac selections, fourth dac word, spi address
      core_group = `MCOD_GRP_PERIPH;                   // [RQ4]
      if (core_field == `MCOD_CORE_SPID)
        core_unit = 2'h0;
    end
  end

endmodule

// *** test/mcod_checker_sva.sv ***
module mcod_checker (
  // clock and reset
  input logic        pclk,
  input logic        presetn,
  // instruction stream
  input logic        instr_valid,
  input logic [15:0] instr_word,
  // decode and add results
  input logic [4:0]  alu_sel_id,
  input logic [4:0]  gpi_sel_id,
  input logic        gpi_sel_ok,
  input logic [2:0]  core_sel_group,
  input logic [1:0]  core_sel_unit,
  input logic [4:0]  core_sel_id,
  input logic [4:0]  jump_sel_id,
  input logic        add_done,
  input logic [6:0]  cond_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_alu_map: assert property (
    instr_valid |=> alu_sel_id == {2'b00, $past(instr_word[2:0])}) else $error("alu select");
  chk_gpi_map: assert property (
    instr_valid |=> gpi_sel_ok == ($past(instr_word[2:0]) <= 3'h5)
      && gpi_sel_id == (($past(instr_word[2:0]) <= 3'h5) ?
                        {2'b00, $past(instr_word[2:0])} : 5'h00))
    else $error("gpi select");
  chk_core_raw: assert property (
    instr_valid |=> core_sel_id == $past(instr_word[4:0])) else $error("core id");
  chk_core_count: assert property (
    instr_valid && instr_word[4:2] == 3'h3 |=> core_sel_group == 3'h4
      && core_sel_unit == $past(instr_word[1:0])) else $error("counter group");
  chk_periph_group: assert property (
    instr_valid && instr_word[4:0] >= 5'h17 && instr_word[4:0] <= 5'h1d
      |=> core_sel_group == 3'h7) else $error("periph group");
  chk_system_group: assert property (
    instr_valid && instr_word[4:0] inside {5'h14, 5'h15, 5'h16, 5'h1e, 5'h1f}
      |=> core_sel_group == 3'h6) else $error("system group");
  chk_jump_map: assert property (
    instr_valid |=> jump_sel_id == ($past(instr_word[0]) ? 5'h0b : 5'h0a)) else $error("jump");
  chk_add_cause: assert property (
    add_done |-> $past(instr_valid) && $past(instr_word[15:10]) == 6'h0a
      && !$past(instr_word[6])) else $error("add without add word");
  chk_add_flags: assert property (
    add_done |-> !cond_flags[3] && cond_flags[4] == cond_flags[0]
      && !(cond_flags[1] && cond_flags[2])) else $error("add flags");
  cover property (add_done && cond_flags[6]);
  cover property (add_done && cond_flags[5]);
  cover property (instr_valid && instr_word[4:0] == 5'h1f);
endmodule

bind mcod_top mcod_checker chk_u (.pclk, .presetn, .instr_valid, .instr_word, .alu_sel_id,
  .gpi_sel_id, .gpi_sel_ok, .core_sel_group, .core_sel_unit, .core_sel_id, .jump_sel_id,
  .add_done, .cond_flags);

// *** test/mcod_code_ram.sv ***
module mcod_code_ram (
  // clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // fetch request
  input  logic        fetch,
  input  logic [5:0]  addr,
  // word to the core
  output logic        instr_valid,
  output logic [15:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:63];
  // outside a fetch the word toggles so a stale sample never looks steady
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_valid <= 1'b0;
      instr_word  <= 16'h0000;
    end else begin
      instr_valid <= fetch;
      instr_word  <= fetch ? mem[addr] : ~instr_word;
    end
  end
endmodule

// *** test/tb_microcore_operand_decoder.sv ***
module tb_microcore_operand_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fetch = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [5:0]  addr = 6'h00;
  logic [15:0] instr_word;
  logic [4:0]  alu_sel_id, gpi_sel_id, core_sel_id, jump_sel_id;
  logic [2:0]  core_sel_group;
  logic [1:0]  core_sel_unit;
  logic [6:0]  cond_flags;
  logic        pready, pslverr, instr_valid, gpi_sel_ok, decode_valid, add_done;
  int          fails = 0, check_count = 0;

  always #25 pclk = ~pclk;

  mcod_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_valid, .instr_word, .alu_sel_id, .gpi_sel_id, .gpi_sel_ok,
    .core_sel_group, .core_sel_unit, .core_sel_id, .jump_sel_id, .decode_valid,
    .add_done, .cond_flags);
  mcod_code_ram ram_u (.pclk, .presetn, .fetch, .addr, .instr_valid, .instr_word);

  task summarize;
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // no wait-state count is assumed; only the bound cuts a dead slave short
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    cmp(r, x);
    cmp(32'(e), 32'(xe));
  endtask

  // one word from code ram; returns once the decode results are settled
  task run(input logic [15:0] w);
    ram_u.mem[0] = w;
    @(posedge pclk);
    fetch <= 1;
    @(posedge pclk);
    fetch <= 0;
    @(posedge pclk);
    @(negedge pclk);
  endtask

  function logic [2:0] grp(input logic [4:0] c);
    if (c < 5'h08) return 3'h0;
    if (c == 5'h08) return 3'h1;
    if (c == 5'h09) return 3'h2;
    if (c < 5'h0c) return 3'h3;
    if (c < 5'h10) return 3'h4;
    if (c < 5'h14) return 3'h5;
    if (c < 5'h17 || c > 5'h1d) return 3'h6;
    return 3'h7;
  endfunction

  function logic [1:0] unit_of(input logic [4:0] c);
    if (c < 5'h0a || c == 5'h17) return 2'h0;
    if (c < 5'h0c) return {1'b0, c[0]};
    return c[1:0];
  endfunction

  task t_reset;
    rd(8'h24, 32'h0, 0);
    rd(8'h20, 32'h0, 0);
    rd(8'h04, 32'h0, 0);
    rd(8'h40, 32'h0, 1);
    rd(8'h02, 32'h0, 1);
  endtask

  task t_decode;
    logic [4:0] c;
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      run({11'h000, c});
      cmp(32'(decode_valid), 32'h1);
      cmp(32'(alu_sel_id), 32'(c[2:0]));
      cmp(32'(gpi_sel_ok), 32'(c[2:0] <= 3'h5));
      cmp(32'(gpi_sel_id), (c[2:0] <= 3'h5) ? 32'(c[2:0]) : 32'h0);
      cmp(32'(core_sel_unit), 32'(unit_of(c)));
      cmp(32'(core_sel_id), 32'(c));
      cmp(32'(core_sel_group), 32'(grp(c)));
      cmp(32'(jump_sel_id), c[0] ? 32'h0b : 32'h0a);
    end
    rd(8'h28, 32'h0000001e, 0);
    rd(8'h2c, 32'h000580ff, 0);
    rd(8'h30, 32'h0000001f, 0);
  endtask

  task t_add;
    wr(8'h24, 32'h1);
    wr(8'h08, 32'h7fff);
    wr(8'h0c, 32'h1);
    run(16'h2893);
    cmp(32'(add_done), 32'h1);
    cmp(32'(cond_flags), 32'h44);
    rd(8'h04, 32'h8000, 0);
    wr(8'h00, 32'hffff);
    wr(8'h14, 32'h1);
    run(16'h2a28);
    cmp(32'(cond_flags), 32'h13);
    rd(8'h10, 32'h0, 0);
    wr(8'h18, 32'h1234);
    run(16'h2b09);
    cmp(32'(cond_flags), 32'h33);
    rd(8'h18, 32'h0, 0);
    rd(8'h20, 32'h33, 0);
    wr(8'h20, 32'h7f);
    rd(8'h20, 32'h0, 0);
  endtask

  task t_refuse;
    run(16'h2ad3);
    cmp(32'(add_done), 32'h0);
    rd(8'h14, 32'h1, 0);
    wr(8'h24, 32'h0);
    run(16'h2a93);
    cmp(32'(add_done), 32'h0);
    rd(8'h14, 32'h1, 0);
    rd(8'h34, {16'h1, 16'h3}, 0);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_decode;
    t_add;
    t_refuse;
    summarize;
  end

  initial begin
    #50000;
    fails++;
    summarize;
  end
endmodule
